// >>> core/ssfb_pkg.sv
package ssfb_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_TEMP = 8'h2e;
  localparam logic [7:0] OFS_PRESS = 8'h30;
  localparam logic [7:0] OFS_MIRROR = 8'h32;
  localparam logic [7:0] OFS_MAIN = 8'h36;
  localparam logic [7:0] OFS_SER_LO = 8'h50;
  localparam logic [7:0] OFS_SER_HI = 8'h52;
  localparam logic [7:0] WORD_STEP = 8'h02;
  // ==========================================================
  // Status field positions
  localparam int BIT_IDLE = 0;
  localparam int BIT_PRESS_UP = 3;
  localparam int BIT_TEMP_UP = 4;
  localparam int BIT_SUPPLY_FAULT = 7;
  localparam int BIT_CHECK_FAULT = 8;
  localparam int BIT_SAT = 10;
  localparam int BIT_CRC_ERR = 11;
  localparam int BIT_PRESS_MISSED = 14;
  localparam int BIT_TEMP_MISSED = 15;
  localparam logic [15:0] EVENT_MASK = 16'hc998;
  // ==========================================================
  // Reset values and link constants
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h6c;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  typedef enum logic [3:0] {
    SSFB_IDLE, SSFB_ADDR, SSFB_ADDR_ACK, SSFB_REG, SSFB_REG_ACK,
    SSFB_WDATA, SSFB_WDATA_ACK, SSFB_RDATA, SSFB_RDATA_ACK
  } ssfb_state_t;
endpackage

// >>> core/ssfb_flag_bank.sv
`timescale 1ns/10ps
module ssfb_flag_bank #(
  parameter logic [6:0] DEV_ADDR = ssfb_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic idle_i,
  input wire logic dsp_sat_i,
  input wire logic bridge_supply_fault_i,
  input wire logic bridge_check_fault_i,
  input wire logic crc_error_i,
  input wire logic temp_load_i,
  input wire logic [15:0] temp_value_i,
  input wire logic press_load_i,
  input wire logic [15:0] press_value_i,
  input wire logic [31:0] serial_number_i,
  output logic [15:0] main_status_o,
  output logic [15:0] mirrored_status_o
);
  // ==========================================================
  // Pin synchronisers and edge detection
  logic scl_s1, scl_s2, scl_s3;
  logic sda_s1, sda_s2, sda_s3;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      {scl_s1, scl_s2, scl_s3} <= 3'h7;
      {sda_s1, sda_s2, sda_s3} <= 3'h7;
    end else if (ce_i) begin
      {scl_s1, scl_s2, scl_s3} <= {scl_i, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_s3} <= {sda_i, sda_s1, sda_s2};
    end
  end

  wire scl_rise = scl_s2 & ~scl_s3;
  wire scl_fall = ~scl_s2 & scl_s3;
  wire start_det = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  wire stop_det = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

  // ==========================================================
  // Link state
  ssfb_pkg::ssfb_state_t state;
  logic [7:0] shift;
  logic [3:0] bit_cnt;
  logic [7:0] reg_ptr;
  logic byte_sel;
  logic rw_read;
  logic master_ack;
  logic [7:0] wr_lo;
  logic [15:0] tx_word;
  logic [7:0] tx_byte;
  logic sda_pull;
  logic wr_pulse;
  logic [15:0] wr_data;
  logic fetch_pulse;
  logic [7:0] fetch_addr_q;

  logic [15:0] main_status;
  logic [1:0] mirror_up;
  logic [15:0] temp_result;
  logic [15:0] press_result;

  // ==========================================================
  // Read decode
  wire [7:0] fetch_addr = byte_sel ? 8'(reg_ptr + ssfb_pkg::WORD_STEP) : reg_ptr;
  wire [15:0] mirrored_status = {main_status[15:5], mirror_up, 2'h0, main_status[ssfb_pkg::BIT_IDLE]};

  // Word selection by register offset; unmapped offsets read zero
  function automatic logic [15:0] read_word(
    input logic [7:0] addr,
    input logic [15:0] temp,
    input logic [15:0] press,
    input logic [15:0] mirror,
    input logic [15:0] status,
    input logic [31:0] ser
  );
    logic [15:0] word;
    word = 16'h0000;
    case (addr)
      ssfb_pkg::OFS_TEMP: begin
        word = temp;
      end
      ssfb_pkg::OFS_PRESS: begin
        word = press;
      end
      ssfb_pkg::OFS_MIRROR: begin
        word = mirror;
      end
      ssfb_pkg::OFS_MAIN: begin
        word = status;
      end
      ssfb_pkg::OFS_SER_LO: begin
        word = ser[15:0];
      end
      ssfb_pkg::OFS_SER_HI: begin
        word = ser[31:16];
      end
      default: begin
        word = 16'h0000;
      end
    endcase
    return word;
  endfunction

  wire [15:0] rd_word = read_word(fetch_addr, temp_result, press_result,
    mirrored_status, main_status, serial_number_i);
  wire addr_match = shift[7:1] == DEV_ADDR;
  wire byte_done = bit_cnt == ssfb_pkg::BITS_PER_BYTE;

  // ==========================================================
  // Two-wire slave
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      state <= ssfb_pkg::SSFB_IDLE;
      shift <= 8'h00;
      bit_cnt <= 4'h0;
      reg_ptr <= 8'h00;
      byte_sel <= 1'b0;
      rw_read <= 1'b0;
      master_ack <= 1'b0;
      wr_lo <= 8'h00;
      tx_word <= 16'h0000;
      tx_byte <= 8'h00;
      sda_pull <= 1'b0;
      wr_pulse <= 1'b0;
      wr_data <= 16'h0000;
      fetch_pulse <= 1'b0;
      fetch_addr_q <= 8'h00;
    end else if (ce_i) begin
      wr_pulse <= 1'b0;
      fetch_pulse <= 1'b0;
      if (start_det) begin
        state <= ssfb_pkg::SSFB_ADDR;
        bit_cnt <= 4'h0;
        byte_sel <= 1'b0;
        sda_pull <= 1'b0;
      end else if (stop_det) begin
        state <= ssfb_pkg::SSFB_IDLE;
        sda_pull <= 1'b0;
      end else if (scl_rise) begin
        case (state)
          ssfb_pkg::SSFB_ADDR, ssfb_pkg::SSFB_REG, ssfb_pkg::SSFB_WDATA: begin
            shift <= {shift[6:0], sda_s2};
            bit_cnt <= bit_cnt + 4'h1;
          end
          ssfb_pkg::SSFB_RDATA_ACK: master_ack <= ~sda_s2;
          default: ;
        endcase
      end else if (scl_fall) begin
        case (state)
          ssfb_pkg::SSFB_ADDR: begin
            if (byte_done && addr_match) begin
              state <= ssfb_pkg::SSFB_ADDR_ACK;
              rw_read <= shift[0];
              sda_pull <= 1'b1;
            end else if (byte_done) begin
              state <= ssfb_pkg::SSFB_IDLE;
            end
          end
          ssfb_pkg::SSFB_ADDR_ACK, ssfb_pkg::SSFB_RDATA_ACK: begin
            if (state == ssfb_pkg::SSFB_ADDR_ACK ? rw_read : master_ack) begin
              state <= ssfb_pkg::SSFB_RDATA;
              bit_cnt <= 4'h1;
              // High byte of the word already fetched follows its low byte
              if (!byte_sel && state == ssfb_pkg::SSFB_RDATA_ACK) begin
                tx_byte <= tx_word[15:8];
                sda_pull <= ~tx_word[15];
              end else begin
                // Word fetched at its low byte; side effects fire here
                tx_word <= rd_word;
                tx_byte <= rd_word[7:0];
                sda_pull <= ~rd_word[7];
                reg_ptr <= fetch_addr;
                fetch_pulse <= 1'b1;
                fetch_addr_q <= fetch_addr;
              end
              byte_sel <= (state == ssfb_pkg::SSFB_RDATA_ACK) ? ~byte_sel : 1'b0;
            end else begin
              state <= (state == ssfb_pkg::SSFB_ADDR_ACK) ? ssfb_pkg::SSFB_REG : ssfb_pkg::SSFB_IDLE;
              bit_cnt <= 4'h0;
              sda_pull <= 1'b0;
            end
          end
          ssfb_pkg::SSFB_REG: begin
            if (byte_done) begin
              state <= ssfb_pkg::SSFB_REG_ACK;
              reg_ptr <= shift;
              byte_sel <= 1'b0;
              sda_pull <= 1'b1;
            end
          end
          ssfb_pkg::SSFB_WDATA: begin
            if (byte_done) begin
              state <= ssfb_pkg::SSFB_WDATA_ACK;
              sda_pull <= 1'b1;
              if (!byte_sel) begin
                wr_lo <= shift;
              end else begin
                wr_pulse <= 1'b1;
                wr_data <= {shift, wr_lo};
              end
            end
          end
          ssfb_pkg::SSFB_REG_ACK, ssfb_pkg::SSFB_WDATA_ACK: begin
            state <= ssfb_pkg::SSFB_WDATA;
            bit_cnt <= 4'h0;
            sda_pull <= 1'b0;
            if (state == ssfb_pkg::SSFB_WDATA_ACK) begin
              byte_sel <= ~byte_sel;
            end
          end
          ssfb_pkg::SSFB_RDATA: begin
            if (byte_done) begin
              state <= ssfb_pkg::SSFB_RDATA_ACK;
              sda_pull <= 1'b0;
            end else begin
              sda_pull <= ~tx_byte[3'(4'h7 - bit_cnt)];
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Write pointer stays put: every written word goes to one register
  wire wr_main = wr_pulse && reg_ptr == ssfb_pkg::OFS_MAIN;

  // ==========================================================
  // Flag bank
  wire rd_temp = fetch_pulse && fetch_addr_q == ssfb_pkg::OFS_TEMP;
  wire rd_press = fetch_pulse && fetch_addr_q == ssfb_pkg::OFS_PRESS;
  wire [15:0] clr_mask = wr_main ? (wr_data & ssfb_pkg::EVENT_MASK) : 16'h0000;
  wire [15:0] set_mask = {
    temp_load_i & main_status[ssfb_pkg::BIT_TEMP_UP],
    press_load_i & main_status[ssfb_pkg::BIT_PRESS_UP],
    2'h0,
    crc_error_i,
    2'h0,
    bridge_check_fault_i,
    bridge_supply_fault_i,
    2'h0,
    temp_load_i,
    press_load_i,
    3'h0};
  wire [15:0] read_clr = {11'h000, rd_temp, rd_press, 3'h0};
  // Set wins over any clear in the same cycle
  wire [15:0] next_events = ((main_status & ~clr_mask & ~read_clr) | set_mask) & ssfb_pkg::EVENT_MASK;
  wire [15:0] live_bits = {5'h00, dsp_sat_i, 9'h000, idle_i};
  wire [15:0] next_main_status = next_events | live_bits;

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      main_status <= ssfb_pkg::STATUS_RESET;
      mirror_up <= 2'h0;
    end else if (ce_i) begin
      main_status <= next_main_status;
      if (rd_temp) begin
        mirror_up[1] <= main_status[ssfb_pkg::BIT_TEMP_UP];
      end
      if (rd_press) begin
        mirror_up[0] <= main_status[ssfb_pkg::BIT_PRESS_UP];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      temp_result <= ssfb_pkg::RESULT_RESET;
      press_result <= ssfb_pkg::RESULT_RESET;
    end else if (ce_i) begin
      if (temp_load_i) begin
        temp_result <= temp_value_i;
      end
      if (press_load_i) begin
        press_result <= press_value_i;
      end
    end
  end

  // ==========================================================
  // Outputs
  assign sda_o = 1'b0;
  assign sda_oe_n_o = ~sda_pull;
  assign main_status_o = main_status;
  assign mirrored_status_o = mirrored_status;
endmodule // ssfb_flag_bank

// >>> verification/ssfb_flag_bank_monitor.sv
`timescale 1ns/10ps
module ssfb_flag_bank_monitor (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic idle_i,
  input wire logic dsp_sat_i,
  input wire logic bridge_supply_fault_i,
  input wire logic bridge_check_fault_i,
  input wire logic crc_error_i,
  input wire logic temp_load_i,
  input wire logic press_load_i,
  input wire logic [15:0] main_status_o,
  input wire logic [15:0] mirrored_status_o
);
  // ==========
  // Status relations
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  AST_MIRROR_COPY: assert property ((mirrored_status_o & 16'hffe1) == (main_status_o & 16'hffe1))
    else $error("mirror differs from main status");
  AST_IDLE_LIVE: assert property (ce_i |=> main_status_o[0] == $past(idle_i))
    else $error("idle bit not live");
  AST_SAT_LIVE: assert property (ce_i |=> main_status_o[10] == $past(dsp_sat_i))
    else $error("saturation bit not live");
  AST_SUPPLY_SET: assert property (ce_i && bridge_supply_fault_i |=> main_status_o[7])
    else $error("supply fault not latched");
  AST_CHECK_SET: assert property (ce_i && bridge_check_fault_i |=> main_status_o[8])
    else $error("check fault not latched");
  AST_CRC_SET: assert property (ce_i && crc_error_i |=> main_status_o[11])
    else $error("checksum error not latched");
  AST_TEMP_UP: assert property (ce_i && temp_load_i |=> main_status_o[4])
    else $error("temperature update flag not set");
  AST_PRESS_UP: assert property (ce_i && press_load_i |=> main_status_o[3])
    else $error("pressure update flag not set");
  AST_TEMP_MISS: assert property (ce_i && temp_load_i && main_status_o[4] |=> main_status_o[15])
    else $error("temperature missed flag not set");
  AST_PRESS_MISS: assert property (ce_i && press_load_i && main_status_o[3] |=> main_status_o[14])
    else $error("pressure missed flag not set");
  AST_RESERVED: assert property (((main_status_o | mirrored_status_o) & 16'h3266) == 16'h0000)
    else $error("reserved status bit set");
endmodule // ssfb_flag_bank_monitor
bind ssfb_flag_bank ssfb_flag_bank_monitor u_mon (.ref_clk_i, .srst_i, .ce_i, .idle_i, .dsp_sat_i,
  .bridge_supply_fault_i, .bridge_check_fault_i, .crc_error_i, .temp_load_i, .press_load_i,
  .main_status_o, .mirrored_status_o);

// >>> verification/ssfb_host.sv
`timescale 1ns/10ps
module ssfb_host #(
  parameter logic [6:0] ADDR = 7'h6c
) (
  input wire logic ref_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  logic nak;
  initial begin
    scl_o = 1'h1;
    sda_o = 1'h1;
    nak = 1'h0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  // ==========
  // Bit: data moves while clock low, sampled at end of high phase
  task automatic bit_io(input logic b, output logic r);
    wt(1);
    sda_o <= b;
    wt(3);
    scl_o <= 1'h1;
    wt(4);
    r = sda_i;
    scl_o <= 1'h0;
  endtask
  // Long low phase lets the device release its acknowledge first
  task automatic start();
    wt(1);
    sda_o <= 1'h1;
    wt(7);
    scl_o <= 1'h1;
    wt(4);
    sda_o <= 1'h0;
    wt(4);
    scl_o <= 1'h0;
  endtask
  task automatic stop();
    wt(1);
    sda_o <= 1'h0;
    wt(3);
    scl_o <= 1'h1;
    wt(4);
    sda_o <= 1'h1;
    wt(4);
  endtask
  task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(m, a);
  endtask
  task automatic wr(input logic [7:0] d);
    logic [7:0] q;
    logic a;
    xfer(d, 1'h1, q, a);
    nak = nak | a;
  endtask
  // Low byte first, one word per write
  task automatic wr_word(input logic [7:0] ra, input logic [15:0] v);
    start();
    wr({ADDR, 1'h0});
    wr(ra);
    wr(v[7:0]);
    wr(v[15:8]);
    stop();
  endtask
  // Burst read, master acknowledges all but the last byte
  task automatic rd(input logic [7:0] ra, input int n, output logic [15:0] w[3]);
    logic a;
    start();
    wr({ADDR, 1'h0});
    wr(ra);
    start();
    wr({ADDR, 1'h1});
    for (int k = 0; k < n; k++) begin
      xfer(8'hff, 1'h0, w[k][7:0], a);
      xfer(8'hff, k == n - 1, w[k][15:8], a);
    end
    stop();
  endtask
endmodule // ssfb_host

// >>> verification/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic ref_clk_i, srst_i, ce_i, idle_i, sat, bsf, bcf, crc, t_ld, p_ld, scl, h_sda, d_sda, d_oe_n, sda;
  logic [15:0] t_val, p_val, ms, mir;
  logic [31:0] ser;
  logic [15:0] w[3];
  int fail_count = 0;
  int cmp_count = 0;
  assign sda = h_sda & (d_oe_n | d_sda);
  ssfb_host u_host (.ref_clk_i(ref_clk_i), .sda_i(sda), .scl_o(scl), .sda_o(h_sda));
  ssfb_flag_bank u_dut (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .ce_i(ce_i), .scl_i(scl), .sda_i(sda),
    .sda_o(d_sda), .sda_oe_n_o(d_oe_n), .idle_i(idle_i), .dsp_sat_i(sat), .bridge_supply_fault_i(bsf),
    .bridge_check_fault_i(bcf), .crc_error_i(crc), .temp_load_i(t_ld), .temp_value_i(t_val),
    .press_load_i(p_ld), .press_value_i(p_val), .serial_number_i(ser), .main_status_o(ms),
    .mirrored_status_o(mir));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cms(input logic [15:0] exp);
    @(negedge ref_clk_i);
    chk(ms, exp);
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic load(input logic is_p, input logic [15:0] v);
    @(posedge ref_clk_i);
    t_val <= v;
    p_val <= v;
    t_ld <= !is_p;
    p_ld <= is_p;
    @(posedge ref_clk_i);
    t_ld <= 1'h0;
    p_ld <= 1'h0;
  endtask
  // ==========
  // Scenarios
  task automatic t_serial();
    u_host.wr_word(8'h50, 16'h0000);
    u_host.rd(8'h50, 2, w);
    chk(w[0], 16'habcd);
    chk(w[1], 16'h1234);
  endtask
  task automatic t_burst();
    idle_i <= 1'h1;
    load(1'h0, 16'h1111);
    load(1'h0, 16'h2222);
    load(1'h1, 16'h3333);
    load(1'h1, 16'h4444);
    u_host.rd(8'h2e, 3, w);
    chk(w[0], 16'h2222);
    chk(w[1], 16'h4444);
    chk(w[2], 16'hc019);
    cms(16'hc001);
    u_host.rd(8'h2e, 3, w);
    chk(w[2], 16'hc001);
    chk({15'h0000, u_host.nak}, 16'h0000);
  endtask
  task automatic t_clear();
    bsf <= 1'h1;
    bcf <= 1'h1;
    crc <= 1'h1;
    sat <= 1'h1;
    @(posedge ref_clk_i);
    bsf <= 1'h0;
    bcf <= 1'h0;
    crc <= 1'h0;
    cms(16'hcd81);
    u_host.wr_word(8'h32, 16'hffff);
    cms(16'hcd81);
    u_host.wr_word(8'h36, 16'h0080);
    cms(16'hcd01);
    sat <= 1'h0;
    idle_i <= 1'h0;
    u_host.wr_word(8'h36, 16'hffff);
    cms(16'h0000);
    chk(mir, 16'h0000);
    chk({15'h0000, d_sda}, 16'h0000);
  endtask
  initial begin
    ref_clk_i = 1'h0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    repeat (100000) @(posedge ref_clk_i);
    fail_count++;
    finish_test();
  end
  initial begin
    {srst_i, ce_i} = 2'h3;
    {idle_i, sat, bsf, bcf, crc, t_ld, p_ld} = 7'h00;
    t_val = 16'h0000;
    p_val = 16'h0000;
    ser = 32'h1234_abcd;
    repeat (12) @(posedge ref_clk_i);
    srst_i <= 1'h0;
    cms(16'h0000);
    chk(mir, 16'h0000);
    repeat (4) @(posedge ref_clk_i);
    t_serial();
    t_burst();
    t_clear();
    finish_test();
  end
endmodule // testbench
